// ---- rtl/mpi_irq.sv ----
// Implementation choice: the AXI4-Lite slave port.
`include "mpi_map.svh"

module mpi_irq (
    input wire logic aclk,
    input wire logic aresetn,
    input wire mpi_pkg::mpi_events_s events,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    localparam int unsigned N = `MPI_SOURCE_COUNT;

    // --------------------------------------------------------------
    // write channel capture
    // --------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [N-1:0] enable;
    logic [N-1:0] raw;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held || aw_take;
    wire w_have = w_held || w_take;
    wire do_write = aw_have && w_have && !s_axi_bvalid;
    wire mpi_pkg::mpi_write_s wr = '{
        addr: aw_held ? aw_addr : s_axi_awaddr,
        data: w_held ? w_data : s_axi_wdata,
        strb: w_held ? w_strb : s_axi_wstrb};

    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = {a[11:2], 2'h0} == off;
    endfunction

    wire wr_enable = do_write && hit(wr.addr, `MPI_ENABLE_OFFSET);
    wire wr_clear = do_write && hit(wr.addr, `MPI_CLEAR_OFFSET);
    wire wr_known = hit(wr.addr, `MPI_ENABLE_OFFSET) || hit(wr.addr, `MPI_CLEAR_OFFSET);
    wire [31:0] wmask = lane_mask(wr.strb);
    // ones clear, zeros leave the bit alone
    wire [N-1:0] clear_bits = wr_clear ? (wr.data[N-1:0] & wmask[N-1:0]) : '0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else
        begin
            aw_held <= aw_have && !do_write;
            w_held <= w_have && !do_write;
            if (aw_take)
                aw_addr <= s_axi_awaddr;
            if (w_take)
            begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    // --------------------------------------------------------------
    // interrupt state
    // --------------------------------------------------------------
    // flat source order, least significant class last in the list, three units per class
    wire [N-1:0] event_bits = {
        events.capture,
        events.trip_oneshot,
        events.trip_cycle,
        events.operator_compare_b_event,
        events.operator_compare_a_event,
        events.fault_end,
        events.fault_begin,
        events.timer_period_event,
        events.timer_zero_event,
        events.timer_halt
    };
    // an event in the same cycle as its clear wins, so none is lost
    wire [N-1:0] next_raw = (raw & ~clear_bits) | event_bits;
    wire [N-1:0] next_enable = wr_enable ?
        ((enable & ~wmask[N-1:0]) | (wr.data[N-1:0] & wmask[N-1:0])) : enable;
    wire [N-1:0] masked = raw & enable;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            raw <= N'(`MPI_RAW_RESET);
            enable <= N'(`MPI_ENABLE_RESET);
            irq <= 1'b0;
        end
        else
        begin
            raw <= next_raw;
            enable <= next_enable;
            irq <= |(next_raw & next_enable);
        end
    end

    // --------------------------------------------------------------
    // write response
    // --------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MPI_RESP_OKAY;
        end
        else
        begin
            // ready drops once a beat is parked so only one write is in flight
            s_axi_awready <= !(aw_have && !do_write) && !do_write && !s_axi_bvalid;
            s_axi_wready <= !(w_have && !do_write) && !do_write && !s_axi_bvalid;
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? `MPI_RESP_OKAY : `MPI_RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // read channel
    // --------------------------------------------------------------
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire rd_enable = hit(s_axi_araddr, `MPI_ENABLE_OFFSET);
    wire rd_raw = hit(s_axi_araddr, `MPI_RAW_OFFSET);
    wire rd_masked = hit(s_axi_araddr, `MPI_MASKED_OFFSET);
    wire rd_clear = hit(s_axi_araddr, `MPI_CLEAR_OFFSET);
    // the clear register reads as zero and a read never disturbs state
    wire [N-1:0] rd_value = rd_enable ? enable : rd_raw ? raw : rd_masked ? masked : '0;
    wire rd_known = rd_enable || rd_raw || rd_masked || rd_clear;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MPI_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !ar_take;
            if (ar_take)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {{(32 - N){1'b0}}, rd_value};
                s_axi_rresp <= rd_known ? `MPI_RESP_OKAY : `MPI_RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    chk_event_sets_raw: assert property (@(posedge aclk) disable iff (!aresetn)
        events[0] |=> raw[0]) else $error("event did not set raw bit");
    chk_raw_needs_event: assert property (@(posedge aclk) disable iff (!aresetn)
        (!raw[16] && !event_bits[16]) |=> !raw[16]) else $error("raw bit set with no event");
    chk_set_beats_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (clear_bits[`MPI_CAPTURE_LSB] && event_bits[`MPI_CAPTURE_LSB])
        |=> raw[`MPI_CAPTURE_LSB]) else $error("event lost to a clear");

    // --------------------------------------------------------------
    // event placement: each struct field lands where software reads it
    // --------------------------------------------------------------
    chk_capture_maps: assert property (@(posedge aclk) disable iff (!aresetn)
        events.capture[1] |=> raw[`MPI_CAPTURE_LSB + 1])
        else $error("capture bit misplaced");
    chk_trip_cycle_maps: assert property (@(posedge aclk) disable iff (!aresetn)
        events.trip_cycle[2] |=> raw[`MPI_TRIP_CYCLE_LSB + 2])
        else $error("cycle trip bit misplaced");
    chk_trip_oneshot_maps: assert property (@(posedge aclk) disable iff (!aresetn)
        events.trip_oneshot[0] |=> raw[`MPI_TRIP_ONESHOT_LSB])
        else $error("one-shot trip bit misplaced");
    chk_fault_begin_maps: assert property (@(posedge aclk) disable iff (!aresetn)
        events.fault_begin[1] |=> raw[`MPI_FAULT_BEGIN_LSB + 1])
        else $error("fault begin bit misplaced");
    chk_fault_end_maps: assert property (@(posedge aclk) disable iff (!aresetn)
        events.fault_end[2] |=> raw[`MPI_FAULT_END_LSB + 2])
        else $error("fault end bit misplaced");
    chk_compare_a_maps: assert property (@(posedge aclk) disable iff (!aresetn)
        events.operator_compare_a_event[0] |=> raw[`MPI_CMP_A_LSB])
        else $error("compare A bit misplaced");
    chk_compare_b_maps: assert property (@(posedge aclk) disable iff (!aresetn)
        events.operator_compare_b_event[1] |=> raw[`MPI_CMP_B_LSB + 1])
        else $error("compare B bit misplaced");
    chk_timer_zero_maps: assert property (@(posedge aclk) disable iff (!aresetn)
        events.timer_zero_event[2] |=> raw[`MPI_TIMER_ZERO_LSB + 2])
        else $error("timer zero bit misplaced");
    chk_timer_period_maps: assert property (@(posedge aclk) disable iff (!aresetn)
        events.timer_period_event[0] |=> raw[`MPI_TIMER_PERIOD_LSB])
        else $error("timer period bit misplaced");
    chk_timer_halt_maps: assert property (@(posedge aclk) disable iff (!aresetn)
        events.timer_halt[1] |=> raw[`MPI_TIMER_HALT_LSB + 1])
        else $error("timer halt bit misplaced");
    chk_capture_pending: assert property (@(posedge aclk) disable iff (!aresetn)
        events.capture[2] ##1 (!clear_bits[29]) [*2] |-> raw[29])
        else $error("capture lost");

    chk_clear_drops_raw: assert property (@(posedge aclk) disable iff (!aresetn)
        (clear_bits[5] && !event_bits[5]) |=> !raw[5]) else $error("clear failed");
    chk_clear_keeps_enable: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_clear |=> enable == $past(enable)) else $error("clear touched enables");
    chk_zero_write_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
        (raw[3] && wr_clear && !wr.data[3]) |=> raw[3]) else $error("pending bit lost");
    chk_clear_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_take && rd_clear) |=> (s_axi_rdata == 32'h0000_0000 && s_axi_rresp == `MPI_RESP_OKAY))
        else $error("clear register read not zero");
    chk_read_no_effect: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_take && !wr_clear && (event_bits == '0)) |=> raw == $past(raw))
        else $error("read disturbed pending bits");

    chk_masked_read_value: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_take && rd_masked) |=> s_axi_rdata == {2'h0, $past(raw & enable)})
        else $error("masked read wrong");
    chk_masked_needs_enable: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_take && rd_masked && !enable[27]) |=> !s_axi_rdata[27])
        else $error("disabled source shown");
    chk_masked_shows_raw: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_take && rd_masked && raw[12] && enable[12]) |=> s_axi_rdata[12])
        else $error("enabled pending source hidden");
    chk_enable_full_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_enable && wr.strb == 4'hf) |=> enable == $past(wr.data[N-1:0]))
        else $error("enable write lost");
    chk_enable_strobe_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_enable && !wr.strb[0]) |=> enable[7:0] == $past(enable[7:0]))
        else $error("unstrobed enable lane changed");

    // irq registers the next state, so it tracks the masked word with no lag
    chk_irq_follows_mask: assert property (@(posedge aclk) disable iff (!aresetn)
        irq == |(raw & enable)) else $error("irq mismatch");
    chk_irq_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        (irq && wr_clear && ((masked & ~clear_bits) == '0) && ((event_bits & enable) == '0))
        |=> !irq) else $error("irq stayed up after its last clear");

    chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid) else $error("no write response");
    chk_write_refused: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_write && !wr_known) |=> s_axi_bresp == `MPI_RESP_SLVERR) else $error("bad write accepted");
    chk_read_refused: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_take && !rd_known) |=> (s_axi_rdata == 32'h0000_0000 && s_axi_rresp == `MPI_RESP_SLVERR))
        else $error("bad read accepted");
    chk_ready_while_busy: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready)) else $error("ready during response");

    // --------------------------------------------------------------
    // cover points
    // --------------------------------------------------------------
    cov_clear_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_clear);
    cov_event_on_clear: cover property (@(posedge aclk) disable iff (!aresetn)
        |(clear_bits & event_bits));
    cov_irq_rise_fall: cover property (@(posedge aclk) disable iff (!aresetn)
        irq ##[1:20] !irq);
    cov_masked_read: cover property (@(posedge aclk) disable iff (!aresetn)
        ar_take && rd_masked);
    cov_strobe_write: cover property (@(posedge aclk) disable iff (!aresetn)
        wr_enable && wr.strb != 4'hf);
endmodule

// ---- rtl/mpi_map.svh ----
`ifndef MPI_MAP_SVH
`define MPI_MAP_SVH

// register byte offsets
`define MPI_ENABLE_OFFSET 12'h110
`define MPI_RAW_OFFSET 12'h114
`define MPI_MASKED_OFFSET 12'h118
`define MPI_CLEAR_OFFSET 12'h11c
`define MPI_ENABLE_RESET 32'h0000_0000
`define MPI_RAW_RESET 32'h0000_0000

// field positions inside every interrupt word
`define MPI_TIMER_HALT_LSB 0
`define MPI_TIMER_ZERO_LSB 3
`define MPI_TIMER_PERIOD_LSB 6
`define MPI_FAULT_BEGIN_LSB 9
`define MPI_FAULT_END_LSB 12
`define MPI_CMP_A_LSB 15
`define MPI_CMP_B_LSB 18
`define MPI_TRIP_CYCLE_LSB 21
`define MPI_TRIP_ONESHOT_LSB 24
`define MPI_CAPTURE_LSB 27
`define MPI_SOURCE_COUNT 30

// axi responses
`define MPI_RESP_OKAY 2'h0
`define MPI_RESP_SLVERR 2'h2

`endif

// ---- rtl/mpi_pkg.sv ----
package mpi_pkg;
    // one bit per unit for each event class
    typedef struct packed {
        logic [2:0] capture;
        logic [2:0] trip_oneshot;
        logic [2:0] trip_cycle;
        logic [2:0] operator_compare_b_event;
        logic [2:0] operator_compare_a_event;
        logic [2:0] fault_end;
        logic [2:0] fault_begin;
        logic [2:0] timer_period_event;
        logic [2:0] timer_zero_event;
        logic [2:0] timer_halt;
    } mpi_events_s;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } mpi_write_s;
endpackage

// ---- dv/tb_top.sv ----
`include "mpi_map.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    mpi_pkg::mpi_events_s events = '0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, raw_m = '0, en_m = '0, rd_v, cv;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [3:0] s_axi_wstrb = 4'hf;
    int err_total = 0;
    int comparisons = 0;

    mpi_irq mpi_irq_inst (
        .aclk, .aresetn, .events, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq
    );

    always #12.5 aclk = ~aclk;

    // ----------------------------------------
    // expectation and bus helpers
    // ----------------------------------------
    function automatic logic [31:0] exp_masked();
        return raw_m & en_m;
    endfunction

    // byte-lane merge that software expects from a strobed write
    function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] d,
        input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return ((old & ~m) | (d & m)) & 32'h3fff_ffff;
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // both beats offered together, each dropped at its own ready
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bit pa;
        bit pw;
        pa = 1'b1;
        pw = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa || pw)
        begin
            @(posedge aclk);
            pa = pa && s_axi_awready !== 1'b1;
            pw = pw && s_axi_wready !== 1'b1;
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        while (s_axi_bvalid !== 1'b1)
            @(posedge aclk);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
            @(posedge aclk);
        while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do
            @(posedge aclk);
        while (s_axi_rvalid !== 1'b1);
        rd_v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic pulse(input logic [31:0] ev);
        events <= ev[29:0];
        @(posedge aclk);
        events <= '0;
        raw_m = raw_m | {2'h0, ev[29:0]};
        @(posedge aclk);
    endtask

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial
    begin
        repeat (20000) @(posedge aclk);
        err_total++;
        report_and_stop();
    end

    initial
    begin
        void'($urandom(31));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`MPI_ENABLE_OFFSET);
        chk("enable reset", rd_v, `MPI_ENABLE_RESET);
        rd(`MPI_RAW_OFFSET);
        chk("raw reset", rd_v, `MPI_RAW_RESET);
        for (int i = 0; i < `MPI_SOURCE_COUNT; i++)
        begin
            pulse(32'h1 << i);
            rd(`MPI_RAW_OFFSET);
            chk("raw", rd_v, raw_m);
            rd(`MPI_MASKED_OFFSET);
            chk("masked off", rd_v, exp_masked());
            chk("irq off", {31'h0, irq}, 32'h0);
            en_m = 32'h1 << i;
            wr(`MPI_ENABLE_OFFSET, en_m);
            chk("enable resp", {30'h0, rs}, {30'h0, `MPI_RESP_OKAY});
            rd(`MPI_MASKED_OFFSET);
            chk("masked on", rd_v, exp_masked());
            chk("irq on", {31'h0, irq}, 32'h1);
            wr(`MPI_CLEAR_OFFSET, ~en_m);
            rd(`MPI_CLEAR_OFFSET);
            chk("clear read", {rd_v[29:0], rs}, 32'h0);
            rd(`MPI_RAW_OFFSET);
            chk("raw kept", rd_v, raw_m);
            wr(`MPI_CLEAR_OFFSET, en_m);
            raw_m = raw_m & ~en_m;
            rd(`MPI_RAW_OFFSET);
            chk("raw cleared", rd_v, raw_m);
            chk("irq cleared", {31'h0, irq}, 32'h0);
        end
        // random mixes of enables, events and clear masks
        repeat (40)
        begin
            en_m = $urandom & 32'h3fff_ffff;
            wr(`MPI_ENABLE_OFFSET, en_m);
            pulse($urandom);
            rd(`MPI_MASKED_OFFSET);
            chk("masked mix", rd_v, exp_masked());
            chk("irq mix", {31'h0, irq}, {31'h0, |exp_masked()});
            cv = $urandom;
            wr(`MPI_CLEAR_OFFSET, cv);
            raw_m = raw_m & ~cv;
            rd(`MPI_RAW_OFFSET);
            chk("raw mix", rd_v, raw_m);
        end
        // partial strobes touch only the selected byte lanes
        s_axi_wstrb <= 4'h6;
        wr(`MPI_ENABLE_OFFSET, 32'hffff_ffff);
        s_axi_wstrb <= 4'hf;
        en_m = lanes(en_m, 32'hffff_ffff, 4'h6);
        rd(`MPI_ENABLE_OFFSET);
        chk("enable strobe", rd_v, en_m);
        s_axi_wstrb <= 4'h9;
        wr(`MPI_CLEAR_OFFSET, 32'hffff_ffff);
        s_axi_wstrb <= 4'hf;
        raw_m = raw_m & ~lanes(32'h0, 32'hffff_ffff, 4'h9);
        rd(`MPI_RAW_OFFSET);
        chk("clear strobe", rd_v, raw_m);
        // a capture held high through its own clear must survive it
        events <= 30'h1 << `MPI_CAPTURE_LSB;
        wr(`MPI_CLEAR_OFFSET, 32'h1 << `MPI_CAPTURE_LSB);
        events <= '0;
        raw_m = raw_m | (32'h1 << `MPI_CAPTURE_LSB);
        rd(`MPI_RAW_OFFSET);
        chk("set beats clear", rd_v, raw_m);
        en_m = 32'h3fff_ffff;
        wr(`MPI_ENABLE_OFFSET, en_m);
        chk("irq all on", {31'h0, irq}, 32'h1);
        // a reset in mid-run wipes pending and enabled sources
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        raw_m = '0;
        en_m = '0;
        chk("irq after reset", {31'h0, irq}, 32'h0);
        rd(`MPI_ENABLE_OFFSET);
        chk("enable after reset", rd_v, `MPI_ENABLE_RESET);
        rd(`MPI_RAW_OFFSET);
        chk("raw after reset", rd_v, `MPI_RAW_RESET);
        // read-only and unmapped places are refused and left untouched
        wr(`MPI_RAW_OFFSET, 32'hffff_ffff);
        chk("raw write resp", {30'h0, rs}, {30'h0, `MPI_RESP_SLVERR});
        rd(`MPI_RAW_OFFSET);
        chk("raw after write", rd_v, raw_m);
        wr(12'h200, 32'hffff_ffff);
        chk("unmapped write", {30'h0, rs}, {30'h0, `MPI_RESP_SLVERR});
        rd(12'h200);
        chk("unmapped read", {rd_v[29:0], rs}, {30'h0, `MPI_RESP_SLVERR});
        report_and_stop();
    end
endmodule
